// file: rtl/watchdog_pkg.sv
// Constants, field layout and types shared by the watchdog timeout unit
package watchdog_pkg;
  // Counter structure
  localparam int PRESC_W    = 12;
  localparam int CNT_W      = 6;
  localparam int SHORT_W    = 7;
  localparam int SVC_CLR_LO = 4;
  localparam int POS_W      = CNT_W + PRESC_W;
  localparam int SPOS_W     = CNT_W + SHORT_W;

  // Timing counts in reference clock cycles
  localparam int TIMEOUT_LONG_CYC  = 262128;
  localparam int TIMEOUT_SHORT_CYC = 8176;
  localparam int POR_CLR_CYC       = 4096;
  localparam int RST_PULSE_CYC     = 32;

  // Register addresses
  localparam logic [15:0] SVC_ADDR   = 16'hffff;
  localparam logic [15:0] CFG_ADDR   = 16'hff1f;
  localparam logic [15:0] CAUSE_ADDR = 16'hff01;
  localparam logic [15:0] STAT_ADDR  = 16'hff20;
  localparam logic [15:0] MASK_ADDR  = 16'hff21;

  // Field positions
  localparam int CFG_DIS_BIT    = 0;
  localparam int CFG_STOPEN_BIT = 1;
  localparam int CFG_RATE_BIT   = 2;
  localparam int CAUSE_WDT_BIT  = 0;
  localparam int EV_OVF_BIT     = 0;
  localparam int EV_SVC_BIT     = 1;

  // Reset values
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] STAT_RST  = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  // Watchdog sequencing states
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_STOPPED = 2'b01,
    ST_HOLD    = 2'b10
  } wdt_state_type;
endpackage

// file: rtl/watchdog_timeout_unit.sv
// Watchdog timeout unit: prescaler, timeout counter, reset pulse and registers
`timescale 1ns/1ps
module watchdog_timeout_unit
  import watchdog_pkg::*;
#(
  parameter int TIMEOUT_LONG  = TIMEOUT_LONG_CYC,
  parameter int TIMEOUT_SHORT = TIMEOUT_SHORT_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire bus_req_type bus_req_i,
  output logic [7:0]       rdata_o,
  input  wire logic [7:0]  reset_vec_lo_i,
  input  wire logic        internal_rst_i,
  input  wire logic        vec_fetch_i,
  input  wire logic        stop_req_i,
  input  wire logic        stop_exit_i,
  input  wire logic        monitor_mode_i,
  input  wire logic        break_active_i,
  input  wire logic        tv_irq_pin_i,
  input  wire logic        tv_rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_o,
  output logic             wdt_rst_o,
  output logic             event_irq_o
);

  localparam logic [POS_W-1:0]  LONG_LAST  = POS_W'(TIMEOUT_LONG - 1);
  localparam logic [SPOS_W-1:0] SHORT_LAST = SPOS_W'(TIMEOUT_SHORT - 1);
  localparam logic [12:0]       POR_LAST   = 13'(POR_CLR_CYC - 1);
  localparam logic [5:0]        HOLD_LAST  = 6'(RST_PULSE_CYC - 1);

  // Write-one-to-clear with set winning over a simultaneous clear
  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] set,
                                     input logic       wr,
                                     input logic [7:0] data);
    logic [7:0] keep;
    keep = wr ? (cur & ~data) : cur;
    return keep | set;
  endfunction

  wdt_state_type        state_ff;
  wdt_state_type        nxt_state;
  logic [PRESC_W-1:0]   presc_ff;
  logic [PRESC_W-1:0]   nxt_presc;
  logic [CNT_W-1:0]     cnt_ff;
  logic [CNT_W-1:0]     nxt_cnt;
  logic [5:0]           hold_cnt_ff;
  logic [12:0]          por_cnt_ff;
  logic                 por_done_ff;
  logic [7:0]           cfg_ff;
  logic [7:0]           cause_ff;
  logic [7:0]           stat_ff;
  logic [7:0]           mask_ff;
  logic [7:0]           rdata_ff;
  logic                 irq_ff;
  logic                 oe_ff;
  logic                 pin_ff;
  logic                 tv_irq_m_ff;
  logic                 tv_irq_s_ff;
  logic                 tv_rst_m_ff;
  logic                 tv_rst_s_ff;

  // Address decode
  wire wr_svc   = bus_req_i.wr && (bus_req_i.addr == SVC_ADDR);
  wire wr_cfg   = bus_req_i.wr && (bus_req_i.addr == CFG_ADDR);
  wire wr_cause = bus_req_i.wr && (bus_req_i.addr == CAUSE_ADDR);
  wire wr_stat  = bus_req_i.wr && (bus_req_i.addr == STAT_ADDR);
  wire wr_mask  = bus_req_i.wr && (bus_req_i.addr == MASK_ADDR);

  // Read selection; unmapped addresses read as zero
  wire [7:0] rd_sel =
    (bus_req_i.addr == SVC_ADDR)   ? reset_vec_lo_i :
    (bus_req_i.addr == CFG_ADDR)   ? cfg_ff :
    (bus_req_i.addr == CAUSE_ADDR) ? cause_ff :
    (bus_req_i.addr == STAT_ADDR)  ? stat_ff :
    (bus_req_i.addr == MASK_ADDR)  ? mask_ff : 8'h00;

  // Configuration fields
  wire cfg_dis    = cfg_ff[CFG_DIS_BIT];
  wire cfg_stopen = cfg_ff[CFG_STOPEN_BIT];
  wire cfg_rate   = cfg_ff[CFG_RATE_BIT];

  // Test-voltage pins are asynchronous, so two flops before use
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tv_irq_m_ff <= 1'b0;
      tv_irq_s_ff <= 1'b0;
      tv_rst_m_ff <= 1'b0;
      tv_rst_s_ff <= 1'b0;
    end else begin
      tv_irq_m_ff <= tv_irq_pin_i;
      tv_irq_s_ff <= tv_irq_m_ff;
      tv_rst_m_ff <= tv_rst_pin_i;
      tv_rst_s_ff <= tv_rst_m_ff;
    end
  end

  // Disable sources: software bit, monitor and break test voltage
  wire mon_off = monitor_mode_i && (tv_irq_s_ff || tv_rst_s_ff);
  wire brk_off = break_active_i && tv_rst_s_ff;
  wire wdt_off = cfg_dis || mon_off || brk_off;

  // Position in the timeout period, per rate
  wire [POS_W-1:0]  long_pos  = {cnt_ff, presc_ff};
  wire [SPOS_W-1:0] short_pos = {cnt_ff, presc_ff[SHORT_W-1:0]};
  wire at_limit = cfg_rate ? (short_pos == SHORT_LAST)
                           : (long_pos == LONG_LAST);
  wire tick = cfg_rate ? (&presc_ff[SHORT_W-1:0])
                       : (&presc_ff);

  // Power-on prescaler clear, one shot after release
  wire por_clr = !por_done_ff && (por_cnt_ff == POR_LAST);

  // Stop only honoured when enabled, so a stray stop cannot halt us
  wire stop_take = stop_req_i && cfg_stopen && (state_ff == ST_RUN);

  wire running = (state_ff == ST_RUN) && !wdt_off;

  // Overflow; a same-cycle service or internal reset wins
  wire ovf = running && at_limit && !wr_svc && !internal_rst_i;

  // Prescaler fully cleared by these sources
  wire presc_clr = internal_rst_i
                || vec_fetch_i
                || por_clr
                || stop_take
                || (state_ff != ST_RUN)
                || wdt_off || ovf;

  // Counter cleared; stop mode holds it instead
  wire cnt_clr = internal_rst_i || wr_svc || ovf
              || (state_ff == ST_HOLD) || wdt_off;

  // Prescaler next value; service keeps only the four low stages
  assign nxt_presc = presc_clr ? '0 :
                     wr_svc ? {{(PRESC_W-SVC_CLR_LO){1'b0}},
                               presc_ff[SVC_CLR_LO-1:0]} :
                     presc_ff + 1'b1;

  // Counter next value; wait mode has no effect here by design
  assign nxt_cnt = cnt_clr ? '0 :
                   (running && tick) ? cnt_ff + 1'b1 :
                   cnt_ff;

  // Sequencing: run, stopped, reset pulse
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (ovf) begin
          nxt_state = ST_HOLD;
        end else if (stop_take) begin
          nxt_state = ST_STOPPED;
        end
      end
      ST_STOPPED: begin
        if (stop_exit_i || internal_rst_i) begin
          nxt_state = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (hold_cnt_ff == HOLD_LAST) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // Counters and state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_RUN;
      presc_ff <= '0;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      presc_ff <= nxt_presc;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Reset pulse length counter
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt_ff <= 6'h00;
    end else if (state_ff == ST_HOLD) begin
      hold_cnt_ff <= hold_cnt_ff + 6'h01;
    end else begin
      hold_cnt_ff <= 6'h00;
    end
  end

  // Power-up delay counter
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      por_cnt_ff  <= 13'h0000;
      por_done_ff <= 1'b0;
    end else if (!por_done_ff) begin
      por_cnt_ff  <= por_cnt_ff + 13'h0001;
      por_done_ff <= por_clr;
    end
  end

  // Software registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff  <= CFG_RST;
      mask_ff <= MASK_RST;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= bus_req_i.wdata;
      end
      if (wr_mask) begin
        mask_ff <= bus_req_i.wdata;
      end
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  wire [7:0] ev_set = 8'((32'(ovf) << EV_OVF_BIT) | (32'(wr_svc) << EV_SVC_BIT));
  wire [7:0] cause_set = 8'(32'(ovf) << CAUSE_WDT_BIT);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cause_ff <= CAUSE_RST;
      stat_ff  <= STAT_RST;
    end else begin
      cause_ff <= w1c(cause_ff, cause_set, wr_cause, bus_req_i.wdata);
      stat_ff  <= w1c(stat_ff, ev_set, wr_stat, bus_req_i.wdata);
    end
  end

  // Outputs, all registered; pin drive follows the hold state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
      irq_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      pin_ff   <= 1'b0;
    end else begin
      rdata_ff <= bus_req_i.rd ? rd_sel : 8'h00;
      irq_ff   <= |(stat_ff & mask_ff);
      oe_ff    <= (nxt_state == ST_HOLD);
      pin_ff   <= 1'b0;
    end
  end

  // Event line is a status summary, never a CPU vectored request
  assign event_irq_o  = irq_ff;
  assign rdata_o      = rdata_ff;
  assign rst_pin_o    = pin_ff;
  assign rst_pin_oe_o = oe_ff;
  assign wdt_rst_o    = oe_ff;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_pulse;
    rst_pin_oe_o[*8] ##1 rst_pin_oe_o[*8] ##1
    rst_pin_oe_o[*8] ##1 rst_pin_oe_o[*8] ##1 !rst_pin_oe_o;
  endsequence

  sequence seq_ovf;
    ovf ##1 (state_ff == ST_HOLD);
  endsequence

  a_pulse_length: assert property ($rose(rst_pin_oe_o) |-> seq_pulse)
    else $error("reset pulse not 32 cycles");
  a_cause_flag: assert property (seq_ovf |-> cause_ff[CAUSE_WDT_BIT] && rst_pin_oe_o)
    else $error("cause flag or pin missing after timeout");
  a_service_clear: assert property (wr_svc |=> cnt_ff == '0 && presc_ff[PRESC_W-1:SVC_CLR_LO] == '0)
    else $error("service did not clear counter");
  a_vector_read: assert property (bus_req_i.rd && bus_req_i.addr == SVC_ADDR
                                  |=> rdata_o == $past(reset_vec_lo_i))
    else $error("service read not vector byte");
  a_disable_quiet: assert property (wdt_off |-> !ovf ##1 (state_ff != ST_HOLD || $past(state_ff) == ST_HOLD))
    else $error("reset while disabled");
  a_tv_disable: assert property ((mon_off || brk_off) |-> !ovf)
    else $error("test voltage did not disable");
  a_internal_clear: assert property (internal_rst_i && state_ff == ST_RUN |=> presc_ff == '0 && cnt_ff == '0)
    else $error("internal reset did not clear");
  a_fetch_clear: assert property (vec_fetch_i && state_ff == ST_RUN |=> presc_ff == '0)
    else $error("vector fetch did not clear prescaler");
  a_stop_gate: assert property (stop_req_i && !cfg_stopen && state_ff == ST_RUN && !ovf
                                |=> state_ff == ST_RUN)
    else $error("stop taken while not enabled");
  a_stop_frozen: assert property (state_ff == ST_STOPPED && !internal_rst_i
                                  |=> presc_ff == '0 && $stable(cnt_ff))
    else $error("counting during stop");
  a_long_limit: assert property (ovf && !cfg_rate |-> long_pos == LONG_LAST)
    else $error("long timeout at wrong count");
  a_tick_advance: assert property (running && tick && !cnt_clr |=> cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("counter did not advance on tick");

  // Short rate must end at its own limit, not the long one
  a_short_limit: assert property (ovf && cfg_rate |-> short_pos == SHORT_LAST)
    else $error("short timeout at wrong count");

  // A taken stop lands in the stopped state with a clean prescaler
  sequence seq_stop_entry;
    stop_take ##1 (state_ff == ST_STOPPED);
  endsequence

  a_stop_clear: assert property (seq_stop_entry |-> presc_ff == '0)
    else $error("stop did not clear prescaler");

  // The one-shot power-up clear empties the prescaler
  a_por_clear: assert property (por_clr |=> presc_ff == '0)
    else $error("power-up clear missed prescaler");

  // The pin is only ever pulled low, never driven high
  a_pin_low: assert property (rst_pin_oe_o |-> !rst_pin_o)
    else $error("reset pin driven high");

  // Event line is a plain registered summary of status and mask
  a_irq_level: assert property (event_irq_o == $past(|(stat_ff & mask_ff)))
    else $error("event line not status summary");

  // While disabled nothing accumulates toward a timeout
  a_off_cleared: assert property (wdt_off |=> cnt_ff == '0 && presc_ff == '0)
    else $error("counting while disabled");

  // The cause flag survives until software clears it
  a_cause_sticky: assert property (cause_ff[CAUSE_WDT_BIT] && !wr_cause |=> cause_ff[CAUSE_WDT_BIT])
    else $error("cause flag lost");

  // Prescaler steps by one each running cycle unless cleared
  a_presc_step: assert property (running && !presc_clr && !wr_svc |=> presc_ff == $past(presc_ff) + 1'b1)
    else $error("prescaler did not step");

  // Stop exit returns to counting on the next cycle
  a_stop_exit: assert property (state_ff == ST_STOPPED && stop_exit_i |=> state_ff == ST_RUN)
    else $error("stop exit not honoured");

  // Read data only stand in the cycle after a read
  a_rdata_idle: assert property (!bus_req_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
endmodule

// file: sim/tb_watchdog_timeout_unit.sv
// Self-checking bench for the watchdog timeout unit
`timescale 1ns/1ps
module tb_watchdog_timeout_unit
  import watchdog_pkg::*;
;
  localparam int TL = 300;
  localparam int TS = 150;
  localparam logic [7:0] VEC = 8'h5a;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  bus_req_type req = '0;
  logic [7:0]  rdata_o, vec_lo;
  logic        irst = 0, vfetch = 0, stopq = 0, stopx = 0, mon = 0, brk = 0, tvi = 0, tvr = 0;
  logic        pin_o, pin_oe, wdt_rst_o, irq_o;
  logic [7:0]  exp_q[$];
  logic        rd_seen = 1'b0;
  logic [31:0] rnd = 32'h6f7339b7;
  int          errors = 0, compares = 0, cyc = 0, width = 0, n;
  logic [4:0]  dis_tab [4] = '{5'b10000, 5'b01010, 5'b01001, 5'b00101};

  watchdog_timeout_unit #(.TIMEOUT_LONG(TL), .TIMEOUT_SHORT(TS)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(req), .rdata_o(rdata_o),
    .reset_vec_lo_i(vec_lo), .internal_rst_i(irst), .vec_fetch_i(vfetch), .stop_req_i(stopq),
    .stop_exit_i(stopx), .monitor_mode_i(mon), .break_active_i(brk), .tv_irq_pin_i(tvi),
    .tv_rst_pin_i(tvr), .rst_pin_o(pin_o), .rst_pin_oe_o(pin_oe), .wdt_rst_o(wdt_rst_o),
    .event_irq_o(irq_o));
  vector_memory_model #(.VEC_LO(VEC)) mem (.reset_vec_lo_o(vec_lo));

  // 25 MHz clock
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bus cycles: one-cycle strobes launched right after the edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
  endtask

  // One-cycle sideband pulse: 0 internal reset, 1 vector fetch, 2 stop, 3 stop exit
  task automatic pulse(input int k);
    @(posedge sys_clk_i);
    case (k)
      0: irst <= 1'b1;
      1: vfetch <= 1'b1;
      2: stopq <= 1'b1;
      default: stopx <= 1'b1;
    endcase
    @(posedge sys_clk_i);
    {irst, vfetch, stopq, stopx} <= 4'h0;
  endtask

  task automatic wait_rise(input int maxc, output int cnt);
    cnt = 0;
    while (wdt_rst_o !== 1'b1 && cnt < maxc) begin
      @(negedge sys_clk_i);
      cnt++;
    end
  endtask

  task automatic wait_fall();
    int c;
    c = 0;
    while (wdt_rst_o !== 1'b0 && c < 100) begin
      @(negedge sys_clk_i);
      c++;
    end
  endtask

  // Read data is noted at issue and compared in the single cycle it stands
  always @(posedge sys_clk_i) rd_seen <= req.rd;
  always @(negedge sys_clk_i) begin
    if (rd_seen) begin
      check(rdata_o, exp_q.pop_front());
    end
  end

  // Reset pin drive checked every pulse cycle, pulse width judged when the pulse ends
  always @(negedge sys_clk_i) begin
    if (wdt_rst_o === 1'b1) begin
      width++;
      check({pin_oe, pin_o}, 2'b10);
    end else if (width != 0) begin
      check(width, RST_PULSE_CYC);
      width = 0;
    end
  end

  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(CFG_ADDR, 8'h00);
    rd(CAUSE_ADDR, 8'h00);
    rd(STAT_ADDR, 8'h00);
    rd(SVC_ADDR, VEC);
    rnd = lfsr(rnd);
    wr({8'hfe, rnd[7:0]}, rnd[15:8]);
    rd({8'hfe, rnd[7:0]}, 8'h00);
    wr(MASK_ADDR, 8'h01);
    // First timeout, then one full long period
    wait_rise(2000, n);
    check(irq_o, 1'b0);
    wait_fall();
    wait_rise(2000, n);
    check(n >= TL - 3 && n <= TL + 3, 1);
    wait_fall();
    rd(CAUSE_ADDR, 8'h01);
    wr(CAUSE_ADDR, 8'h01);
    rd(CAUSE_ADDR, 8'h00);
    rd(STAT_ADDR, 8'h01);
    check(irq_o, 1'b1);
    wr(MASK_ADDR, 8'h00);
    repeat (2) @(negedge sys_clk_i);
    check(irq_o, 1'b0);
    wr(STAT_ADDR, 8'h01);
    wr(MASK_ADDR, 8'h01);
    repeat (2) @(negedge sys_clk_i);
    check(irq_o, 1'b0);
    // Short rate
    wr(CFG_ADDR, 8'h04);
    wait_rise(2000, n);
    wait_fall();
    wait_rise(2000, n);
    check(n >= TS - 3 && n <= TS + 3, 1);
    wr(CFG_ADDR, 8'h00);
    // Late service, internal reset and vector fetch each restart the period
    for (int k = 0; k < 3; k++) begin
      wait_fall();
      wait_rise(2000, n);
      wait_fall();
      repeat (TL - 50) @(posedge sys_clk_i);
      rnd = lfsr(rnd);
      if (k == 0) wr(SVC_ADDR, rnd[7:0]);
      else pulse(k - 1);
      wait_rise(200, n);
      check(wdt_rst_o, 1'b0);
    end
    // Every disabling condition holds off the reset
    for (int k = 0; k < 4; k++) begin
      wait_fall();
      wr(CFG_ADDR, {7'h0, dis_tab[k][4]});
      {mon, brk, tvi, tvr} <= dis_tab[k][3:0];
      wait_rise(700, n);
      check(wdt_rst_o, 1'b0);
      @(posedge sys_clk_i);
      {mon, brk, tvi, tvr} <= 4'h0;
    end
    wr(CFG_ADDR, 8'h00);
    wait_rise(TL + 20, n);
    check(wdt_rst_o, 1'b1);
    // Stop only halts counting when stop is enabled
    wait_fall();
    wr(CFG_ADDR, 8'h02);
    pulse(2);
    wait_rise(700, n);
    check(wdt_rst_o, 1'b0);
    pulse(3);
    wr(CFG_ADDR, 8'h00);
    pulse(2);
    wait_rise(TL + 20, n);
    check(wdt_rst_o, 1'b1);
    wait_fall();
    report_and_stop();
  end
endmodule

// file: sim/vector_memory_model.sv
// Reset vector memory seen by the watchdog on reads of the service location
`timescale 1ns/1ps
module vector_memory_model #(
  parameter logic [7:0] VEC_LO = 8'h5a
) (
  output logic [7:0] reset_vec_lo_o
);
  // Low byte of the reset vector; a fixed image, as in nonvolatile memory
  assign reset_vec_lo_o = VEC_LO;
endmodule
